// >>> cdts_lane_seq.sv
`timescale 1ns/10ps
module cdts_lane_seq (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Configuration
	input wire logic enable_i,
	input wire logic [3:0] lane_is_clk_i,
	input wire logic [3:0] inv_p_i,
	input wire logic [3:0] inv_n_i,
	// Payload stream
	input wire logic [7:0] data_i,
	input wire logic valid_i,
	input wire logic last_i,
	output logic ready_o,
	// Lane wires
	output logic [3:0] hs_p_o,
	output logic [3:0] hs_n_o,
	output logic [3:0] lp_p_o,
	output logic [3:0] lp_n_o,
	output logic [3:0] hs_oe_n_o,
	// Status
	output logic clk_running_o,
	output logic busy_o
);
	// ****************************************************************
	// Clock lane sequencer
	// ****************************************************************
	cdts_pkg::cdts_cl_t cl_st;
	cdts_pkg::cdts_cl_t next_cl_st;
	logic [cdts_pkg::CNT_W-1:0] cl_cnt;
	logic [cdts_pkg::CNT_W-1:0] next_cl_cnt;
	logic ddr_ph;
	logic next_ddr_ph;
	always_comb begin
		next_cl_st = cl_st;
		next_cl_cnt = cl_cnt + 8'h01;
		next_ddr_ph = 1'b0;
		case (cl_st)
			cdts_pkg::CL_STOP: begin
				next_cl_cnt = 8'h00;
				if (enable_i) begin
					next_cl_st = cdts_pkg::CL_LP01;
				end
			end
			// [RL12] LP state length.
			cdts_pkg::CL_LP01: begin
				if (cl_cnt == 8'(cdts_pkg::CYC_LPX - 1)) begin
					next_cl_st = cdts_pkg::CL_LP00;
					next_cl_cnt = 8'h00;
				end
			end
			// [RL5] Clock prepare window.
			cdts_pkg::CL_LP00: begin
				if (cl_cnt == 8'(cdts_pkg::CYC_CLK_PREP - 1)) begin
					next_cl_st = cdts_pkg::CL_ZERO;
					next_cl_cnt = 8'h00;
				end
			end
			// [RL6] Prepare plus zero.
			cdts_pkg::CL_ZERO: begin
				if (cl_cnt == 8'(cdts_pkg::CYC_CLK_ZERO - 1)) begin
					next_cl_st = cdts_pkg::CL_RUN;
					next_cl_cnt = 8'h00;
				end
			end
			// [RL3] Clock always toggles.
			cdts_pkg::CL_RUN: begin
				next_ddr_ph = ~ddr_ph;
				if (cl_cnt == 8'hff) begin
					next_cl_cnt = cl_cnt;
				end
				if (!enable_i) begin
					next_cl_st = cdts_pkg::CL_STOP;
				end
			end
			default: begin
				next_cl_st = cdts_pkg::CL_STOP;
			end
		endcase
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cl_st <= cdts_pkg::CL_STOP;
			cl_cnt <= 8'h00;
			ddr_ph <= 1'b0;
		end else begin
			cl_st <= next_cl_st;
			cl_cnt <= next_cl_cnt;
			ddr_ph <= next_ddr_ph;
		end
	end
	// ****************************************************************
	// Clock lead before bursts
	// ****************************************************************
	// [RL4] Clock pre time.
	logic clk_pre_ok;
	assign clk_pre_ok = (cl_st == cdts_pkg::CL_RUN) &&
		(cl_cnt >= 8'(cdts_pkg::CYC_CLK_PRE));
	// ****************************************************************
	// Data lane sequencer
	// ****************************************************************
	cdts_pkg::cdts_dl_t dl_st;
	cdts_pkg::cdts_dl_t next_dl_st;
	logic [cdts_pkg::CNT_W-1:0] dl_cnt;
	logic [cdts_pkg::CNT_W-1:0] next_dl_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [2:0] bit_idx;
	logic [2:0] next_bit_idx;
	logic end_burst;
	logic next_end_burst;
	logic last_bit;
	logic next_last_bit;
	logic take;
	always_comb begin
		next_dl_st = dl_st;
		next_dl_cnt = dl_cnt + 8'h01;
		next_shreg = shreg;
		next_bit_idx = bit_idx;
		next_end_burst = end_burst;
		next_last_bit = last_bit;
		take = 1'b0;
		case (dl_st)
			// [RL14] Idle in LP-11.
			cdts_pkg::DL_STOP: begin
				next_dl_cnt = 8'h00;
				if (valid_i && clk_pre_ok) begin
					next_dl_st = cdts_pkg::DL_LP01;
				end
			end
			// [RL12] LP-01 length.
			cdts_pkg::DL_LP01: begin
				if (dl_cnt == 8'(cdts_pkg::CYC_LPX - 1)) begin
					next_dl_st = cdts_pkg::DL_LP00;
					next_dl_cnt = 8'h00;
				end
			end
			// [RL7] Data prepare.
			cdts_pkg::DL_LP00: begin
				if (dl_cnt == 8'(cdts_pkg::CYC_HS_PREP - 1)) begin
					next_dl_st = cdts_pkg::DL_ZERO;
					next_dl_cnt = 8'h00;
				end
			end
			// [RL8] Prepare plus zero.
			cdts_pkg::DL_ZERO: begin
				if (dl_cnt == 8'(cdts_pkg::CYC_HS_ZERO - 1)) begin
					next_dl_st = cdts_pkg::DL_SYNC;
					next_dl_cnt = 8'h00;
					next_shreg = cdts_pkg::SYNC_BYTE;
					next_bit_idx = 3'h0;
				end
			end
			cdts_pkg::DL_SYNC: begin
				next_bit_idx = bit_idx + 3'h1;
				next_shreg = {1'b0, shreg[7:1]};
				if (bit_idx == 3'h7) begin
					next_last_bit = shreg[0];
					if (valid_i) begin
						take = 1'b1;
						next_shreg = data_i;
						next_end_burst = last_i;
						next_dl_st = cdts_pkg::DL_PAY;
					end else begin
						next_dl_st = cdts_pkg::DL_TRAIL;
						next_dl_cnt = 8'h00;
					end
				end
			end
			// [RL13] One bit per cycle.
			cdts_pkg::DL_PAY: begin
				next_bit_idx = bit_idx + 3'h1;
				next_dl_cnt = 8'h00;
				next_shreg = {1'b0, shreg[7:1]};
				if (bit_idx == 3'h7) begin
					next_last_bit = shreg[0];
					if (end_burst || !valid_i) begin
						next_dl_st = cdts_pkg::DL_TRAIL;
					end else begin
						take = 1'b1;
						next_shreg = data_i;
						next_end_burst = last_i;
					end
				end
			end
			// [RL9] Flipped trail.
			cdts_pkg::DL_TRAIL: begin
				// [RL10] End of transmission bound.
				if (dl_cnt == 8'(cdts_pkg::CYC_TRAIL - 1)) begin
					next_dl_st = cdts_pkg::DL_EXIT;
					next_dl_cnt = 8'h00;
				end
			end
			// [RL11] LP-11 exit time.
			cdts_pkg::DL_EXIT: begin
				if (dl_cnt == 8'(cdts_pkg::CYC_EXIT - 1)) begin
					next_dl_st = cdts_pkg::DL_STOP;
					next_dl_cnt = 8'h00;
				end
			end
			default: begin
				next_dl_st = cdts_pkg::DL_STOP;
			end
		endcase
		if (!enable_i) begin
			next_dl_st = cdts_pkg::DL_STOP;
			take = 1'b0;
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dl_st <= cdts_pkg::DL_STOP;
			dl_cnt <= 8'h00;
			shreg <= 8'h00;
			bit_idx <= 3'h0;
			end_burst <= 1'b0;
			last_bit <= 1'b0;
		end else begin
			dl_st <= next_dl_st;
			dl_cnt <= next_dl_cnt;
			shreg <= next_shreg;
			bit_idx <= next_bit_idx;
			end_burst <= next_end_burst;
			last_bit <= next_last_bit;
		end
	end
	// ****************************************************************
	// Payload handshake
	// ****************************************************************
	assign ready_o = take;
	// ****************************************************************
	// Lane mapping and wire drivers
	// ****************************************************************
	logic d_hs_en;
	logic d_hs_bit;
	logic d_lp_p;
	logic d_lp_n;
	logic c_hs_en;
	logic c_lp_p;
	logic c_lp_n;
	always_comb begin
		d_hs_en = 1'b0;
		d_hs_bit = 1'b0;
		d_lp_p = 1'b1;
		d_lp_n = 1'b1;
		case (dl_st)
			cdts_pkg::DL_LP01: begin
				d_lp_p = 1'b0;
			end
			cdts_pkg::DL_LP00: begin
				d_lp_p = 1'b0;
				d_lp_n = 1'b0;
			end
			cdts_pkg::DL_ZERO: begin
				d_hs_en = 1'b1;
			end
			cdts_pkg::DL_SYNC, cdts_pkg::DL_PAY: begin
				d_hs_en = 1'b1;
				d_hs_bit = shreg[0];
			end
			cdts_pkg::DL_TRAIL: begin
				d_hs_en = 1'b1;
				d_hs_bit = ~last_bit;
			end
			default: begin
				d_hs_en = 1'b0;
			end
		endcase
		c_hs_en = (cl_st == cdts_pkg::CL_ZERO) || (cl_st == cdts_pkg::CL_RUN);
		c_lp_p = !(cl_st == cdts_pkg::CL_LP01 || cl_st == cdts_pkg::CL_LP00);
		c_lp_n = cl_st != cdts_pkg::CL_LP00;
	end
	// [RL1] Per-lane role select.
	genvar gi;
	generate
		for (gi = 0; gi < cdts_pkg::NUM_LANES; gi++) begin : g_lane
			cdts_lane_if lif();
			assign lif.hs_en = lane_is_clk_i[gi] ? c_hs_en : d_hs_en;
			assign lif.hs_bit = lane_is_clk_i[gi] ? ddr_ph : d_hs_bit;
			assign lif.lp_p = lane_is_clk_i[gi] ? c_lp_p : d_lp_p;
			assign lif.lp_n = lane_is_clk_i[gi] ? c_lp_n : d_lp_n;
			// [RL2] Per-wire polarity.
			assign lif.swap_p = inv_p_i[gi];
			assign lif.swap_n = inv_n_i[gi];
			cdts_lane_drv u_drv (
				.ref_clk_i(ref_clk_i),
				.rst_i(rst_i),
				.lane(lif.drv)
			);
			assign hs_p_o[gi] = lif.hs_p;
			assign hs_n_o[gi] = lif.hs_n;
			assign lp_p_o[gi] = lif.lpo_p;
			assign lp_n_o[gi] = lif.lpo_n;
			assign hs_oe_n_o[gi] = lif.oe_hs;
		end
	endgenerate
	// ****************************************************************
	// Status outputs
	// ****************************************************************
	assign clk_running_o = cl_st == cdts_pkg::CL_RUN;
	assign busy_o = dl_st != cdts_pkg::DL_STOP;
endmodule // cdts_lane_seq

// >>> cdts_pkg.sv
// Contract
// [RL1] Four lanes, each selectable as data lane or forwarded clock lane.
// [RL2] Each lane inverts its positive and negative wire independently.
// [RL3] Clock lane toggles in high-speed mode continuously once enabled.
// [RL4] HS clock runs at least 8 ns before data lanes leave LP.
// [RL5] Clock lane holds LP-00 between 38 and 95 ns before HS-0.
// [RL6] Clock lane prepare plus HS-0 zero lasts at least 300 ns.
// [RL7] Data prepare lasts 40 ns plus 4 UI to 85 ns plus 6 UI.
// [RL8] Data prepare plus HS-0 zero lasts at least 145 ns plus 10 UI.
// [RL9] Trail holds flipped state max of 8 UI or 60 ns plus 4 UI.
// [RL10] Trail start to LP-11 stays within 105 ns plus 12 UI.
// [RL11] Data lane stays in LP-11 at least 100 ns after a burst.
// [RL12] Every low-power state during entry lasts at least 50 ns.
// [RL13] Unit interval never shorter than 1.131 ns.
// [RL14] Data lanes step LP-11, LP-01, LP-00, HS-0, sync, payload, trail, LP-11.
package cdts_pkg;
	localparam int CLK_PS = 4000;
	localparam int NUM_LANES = 4;
	// Unit interval is one ref_clk cycle: 4 ns, well above 1.131 ns.
	localparam int UI_PS = CLK_PS;
	localparam int UI_MIN_PS = 1131;
	localparam int T_CLK_PRE_NS = 8;
	localparam int T_CLK_PREP_NS = 60;
	localparam int T_CLK_PREP_ZERO_NS = 300;
	localparam int T_HS_PREP_NS = 60;
	localparam int T_HS_PREP_ZERO_NS = 145;
	localparam int T_TRAIL_NS = 60;
	localparam int T_EXIT_NS = 100;
	localparam int T_LPX_NS = 50;
	localparam int SYNC_BITS = 8;
	localparam logic [7:0] SYNC_BYTE = 8'hb8;
	localparam int CYC_CLK_PRE = (T_CLK_PRE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_CLK_PREP = (T_CLK_PREP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_CLK_ZERO =
		(T_CLK_PREP_ZERO_NS * 1000 + CLK_PS - 1) / CLK_PS - CYC_CLK_PREP;
	localparam int CYC_HS_PREP =
		(T_HS_PREP_NS * 1000 + 5 * UI_PS + CLK_PS - 1) / CLK_PS;
	localparam int CYC_HS_ZERO =
		(T_HS_PREP_ZERO_NS * 1000 + 10 * UI_PS + CLK_PS - 1) / CLK_PS
		- CYC_HS_PREP;
	localparam int TRAIL_A = 8 * UI_PS;
	localparam int TRAIL_B = T_TRAIL_NS * 1000 + 4 * UI_PS;
	localparam int CYC_TRAIL =
		((TRAIL_A > TRAIL_B ? TRAIL_A : TRAIL_B) + CLK_PS - 1) / CLK_PS;
	localparam int CYC_EXIT = (T_EXIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CYC_LPX = (T_LPX_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CNT_W = 8;
	typedef enum logic [3:0] {
		DL_STOP = 4'h0,
		DL_LP01 = 4'h1,
		DL_LP00 = 4'h3,
		DL_ZERO = 4'h2,
		DL_SYNC = 4'h6,
		DL_PAY = 4'h7,
		DL_TRAIL = 4'h5,
		DL_EXIT = 4'h4
	} cdts_dl_t;
	typedef enum logic [2:0] {
		CL_STOP = 3'h0,
		CL_LP01 = 3'h1,
		CL_LP00 = 3'h3,
		CL_ZERO = 3'h2,
		CL_RUN = 3'h6
	} cdts_cl_t;
endpackage

// >>> cdts_lane_if.sv
`timescale 1ns/10ps
interface cdts_lane_if;
	logic hs_en;
	logic hs_bit;
	logic lp_p;
	logic lp_n;
	logic swap_p;
	logic swap_n;
	logic hs_p;
	logic hs_n;
	logic lpo_p;
	logic lpo_n;
	logic oe_hs;
	modport core(output hs_en, hs_bit, lp_p, lp_n, swap_p, swap_n,
		input hs_p, hs_n, lpo_p, lpo_n, oe_hs);
	modport drv(input hs_en, hs_bit, lp_p, lp_n, swap_p, swap_n,
		output hs_p, hs_n, lpo_p, lpo_n, oe_hs);
endinterface // cdts_lane_if

// >>> cdts_lane_drv.sv
`timescale 1ns/10ps
module cdts_lane_drv (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Lane
	cdts_lane_if.drv lane
);
	logic next_hs_p;
	logic next_hs_n;
	logic next_lp_p;
	logic next_lp_n;
	logic next_oe;
	logic r_hs_p;
	logic r_hs_n;
	logic r_lp_p;
	logic r_lp_n;
	logic r_oe;
	// [RL2] Wire polarity inversion.
	always_comb begin
		next_hs_p = lane.hs_bit ^ lane.swap_p;
		next_hs_n = ~lane.hs_bit ^ lane.swap_n;
		next_lp_p = lane.lp_p ^ lane.swap_p;
		next_lp_n = lane.lp_n ^ lane.swap_n;
		next_oe = ~lane.hs_en;
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r_hs_p <= 1'b0;
			r_hs_n <= 1'b1;
			r_lp_p <= 1'b1;
			r_lp_n <= 1'b1;
			r_oe <= 1'b1;
		end else begin
			r_hs_p <= next_hs_p;
			r_hs_n <= next_hs_n;
			r_lp_p <= next_lp_p;
			r_lp_n <= next_lp_n;
			r_oe <= next_oe;
		end
	end
	assign lane.hs_p = r_hs_p;
	assign lane.hs_n = r_hs_n;
	assign lane.lpo_p = r_lp_p;
	assign lane.lpo_n = r_lp_n;
	assign lane.oe_hs = r_oe;
endmodule // cdts_lane_drv

// >>> cdts_rx_model.sv
`timescale 1ns/10ps
// ********
// Receiver
// ********
module cdts_rx_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Lane wires
	input wire logic hs_i,
	input wire logic oe_n_i,
	input wire logic inv_i,
	// Received bytes
	output logic [7:0] byte_o,
	output logic byte_v_o
);
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic [2:0] bc;
	logic sync;
	assign next_sh = {hs_i ^ inv_i, sh[7:1]};
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh <= 8'h00;
			bc <= 3'h0;
			sync <= 1'b0;
			byte_o <= 8'h00;
			byte_v_o <= 1'b0;
		end else begin
			sh <= oe_n_i ? 8'h00 : next_sh;
			byte_o <= next_sh;
			byte_v_o <= sync && bc == 3'h7 && !oe_n_i;
			bc <= sync ? bc + 3'h1 : 3'h0;
			if (oe_n_i) begin
				sync <= 1'b0;
			end else if (next_sh == cdts_pkg::SYNC_BYTE) begin
				sync <= 1'b1;
			end
		end
	end
endmodule // cdts_rx_model

// >>> cdts_lane_seq_chk.sv
`timescale 1ns/10ps
// ********
// Checker
// ********
module cdts_lane_seq_chk (
	// Clock, reset and setup
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic [3:0] lane_is_clk_i,
	input wire logic [3:0] inv_p_i,
	input wire logic [3:0] inv_n_i,
	// Outputs watched
	input wire logic [3:0] hs_p_o,
	input wire logic [3:0] lp_p_o,
	input wire logic [3:0] lp_n_o,
	input wire logic [3:0] hs_oe_n_o,
	input wire logic clk_running_o
);
	logic [2:0] s;
	logic [2:0] s_q;
	logic h;
	logic h_q;
	logic inv_p_q;
	logic inv_n_q;
	logic [7:0] cnt;
	logic [7:0] hcnt;
	logic [7:0] z;
	assign s = {hs_oe_n_o[0], lp_p_o[0] ^ inv_p_q, lp_n_o[0] ^ inv_n_q};
	assign h = hs_p_o[0] ^ inv_p_q;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			inv_p_q <= 1'b0;
			inv_n_q <= 1'b0;
			s_q <= 3'h7;
			h_q <= 1'b0;
			cnt <= 8'h00;
			hcnt <= 8'h00;
			z <= 8'hff;
		end else begin
			inv_p_q <= inv_p_i[0];
			inv_n_q <= inv_n_i[0];
			s_q <= s;
			h_q <= h;
			cnt <= (s != s_q) ? 8'h01 : cnt + 8'(cnt != 8'hff);
			hcnt <= (h != h_q || s[2]) ? 8'h01 : hcnt + 8'(hcnt != 8'hff);
			z <= (s == 3'h4 && s_q != 3'h4) ? 8'h01 : z + 8'(z != 8'hff);
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i || !enable_i || lane_is_clk_i[0]);
	AST_LP01_MIN: assert property (
		s != s_q && s_q == 3'h5 |-> cnt >= 8'h0d) else $error("LP-01 short.");
	AST_PREP_WIN: assert property (
		s != s_q && s_q == 3'h4 |-> cnt >= 8'h0e && cnt <= 8'h1b)
		else $error("Data prepare out of window.");
	AST_LP01_FROM: assert property (
		s == 3'h5 && s_q != 3'h5 |-> s_q == 3'h7) else $error("Bad LP-01 entry.");
	AST_LP00_FROM: assert property (
		s == 3'h4 && s_q != 3'h4 |-> s_q == 3'h5) else $error("Bad LP-00 entry.");
	AST_ZERO_MIN: assert property (
		!s[2] && h |-> z >= 8'h32) else $error("Prepare plus zero short.");
	AST_TRAIL_MIN: assert property (
		s[2] && !s_q[2] |-> hcnt >= 8'h13) else $error("Trail short.");
	AST_TRAIL_FLIP: assert property (
		s[2] && !s_q[2] |-> hcnt == 8'(cdts_pkg::CYC_TRAIL))
		else $error("Trail not flipped from last bit.");
	AST_EOT_MAX: assert property (
		s[2] && !s_q[2] |-> s == 3'h7 && hcnt <= 8'h26)
		else $error("End of burst late.");
	AST_EXIT_MIN: assert property (
		s == 3'h5 && s_q == 3'h7 |-> cnt >= 8'h19) else $error("Exit short.");
	AST_CLK_PRE: assert property (
		s == 3'h5 && s_q == 3'h7 |-> clk_running_o && $past(clk_running_o, 2))
		else $error("Clock not running before burst.");
	AST_CLK_TOGGLE: assert property (
		clk_running_o && $past(clk_running_o, 2) |->
		((hs_p_o ^ $past(hs_p_o)) & lane_is_clk_i) == lane_is_clk_i &&
		(hs_oe_n_o & lane_is_clk_i) == 4'h0) else $error("Clock lane stalled.");
endmodule // cdts_lane_seq_chk
bind cdts_lane_seq cdts_lane_seq_chk u_chk (.ref_clk_i, .rst_i, .enable_i,
	.lane_is_clk_i, .inv_p_i, .inv_n_i, .hs_p_o, .lp_p_o, .lp_n_o,
	.hs_oe_n_o, .clk_running_o);

// >>> cdts_lane_seq_tb.sv
`timescale 1ns/10ps
// ********
// Testbench
// ********
module cdts_lane_seq_tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic enable_i = 1'b0;
	logic [3:0] lane_is_clk_i = 4'h8;
	logic [3:0] inv_p_i = 4'h0;
	logic [3:0] inv_n_i = 4'h0;
	logic [7:0] data_i = 8'h00;
	logic valid_i = 1'b0;
	logic last_i = 1'b0;
	logic ready_o, clk_running_o, busy_o, rx_v;
	logic [3:0] hs_p_o, hs_n_o, lp_p_o, lp_n_o, hs_oe_n_o;
	logic [7:0] rx_byte;
	logic [7:0] rxq[$];
	int n_fail = 0;
	int samples_checked = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	cdts_lane_seq uut (.ref_clk_i, .rst_i, .enable_i, .lane_is_clk_i,
		.inv_p_i, .inv_n_i, .data_i, .valid_i, .last_i, .ready_o, .hs_p_o,
		.hs_n_o, .lp_p_o, .lp_n_o, .hs_oe_n_o, .clk_running_o, .busy_o);
	cdts_rx_model rx (.ref_clk_i, .rst_i, .hs_i(hs_p_o[0]),
		.oe_n_i(hs_oe_n_o[0]), .inv_i(inv_p_i[0]), .byte_o(rx_byte),
		.byte_v_o(rx_v));
	always @(posedge ref_clk_i) if (rx_v) rxq.push_back(rx_byte);
	task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic t_clk(input int ln);
		int p;
		int z;
		int k;
		p = 0;
		z = 0;
		@(negedge ref_clk_i);
		enable_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		lane_is_clk_i = 4'h1 << ln;
		enable_i = 1'b1;
		for (k = 0; k < 400 && !(hs_oe_n_o[ln] === 1'b0 &&
				hs_p_o[ln] === 1'b1); k++) begin
			@(negedge ref_clk_i);
			if (hs_oe_n_o[ln] && !lp_p_o[ln] && !lp_n_o[ln]) p++;
			if (!hs_oe_n_o[ln] && !hs_p_o[ln]) z++;
		end
		chk("clk prepare", 8'h01, 8'(p >= 10 && p <= 23));
		chk("clk zero", 8'h01, 8'(p + z >= 75));
		$display("test clock lane %0d done", ln);
	endtask
	task automatic t_burst(input int n, input logic [7:0] b0, input logic inv);
		int i;
		int k;
		int bad;
		bad = 0;
		if (inv_p_i[0] !== inv) begin
			@(negedge ref_clk_i);
			inv_p_i = {3'h0, inv};
			repeat (30) @(negedge ref_clk_i);
			chk("idle lp", {6'h0, ~inv, 1'b1}, {6'h0, lp_p_o[0], lp_n_o[0]});
		end
		rxq.delete();
		valid_i = 1'b1;
		for (i = 0; i < n; i++) begin
			data_i = b0 + 8'(i);
			last_i = (i == n - 1);
			for (k = 0; k < 400 && ready_o !== 1'b1; k++) begin
				@(negedge ref_clk_i);
				if (!hs_oe_n_o[0] && hs_n_o[0] !== (hs_p_o[0] ^ ~inv)) bad++;
			end
			@(negedge ref_clk_i);
		end
		valid_i = 1'b0;
		last_i = 1'b0;
		for (k = 0; k < 400 && (busy_o !== 1'b0 || hs_oe_n_o[0] !== 1'b1); k++)
			@(negedge ref_clk_i);
		chk("hs wires", 8'h00, 8'(bad));
		chk("rx count", 8'h01, 8'(rxq.size() >= n));
		for (i = 0; i < n && i < rxq.size(); i++)
			chk("rx byte", b0 + 8'(i), rxq[i]);
		$display("test burst %0d done", n);
	endtask
	initial begin
		repeat (16) @(negedge ref_clk_i);
		rst_i = 1'b0;
		t_clk(3);
		t_burst(1, 8'h5a, 1'b0);
		t_burst(3, 8'h80, 1'b0);
		t_burst(4, 8'hfe, 1'b1);
		t_clk(1);
		t_burst(2, 8'h01, 1'b0);
		print_verdict();
	end
	initial begin
		#100000;
		n_fail++;
		print_verdict();
	end
endmodule // cdts_lane_seq_tb
